// ### rtl/led_ramp_defs.svh
// Register map, reset values, field positions and timing constants
// Overview of operation
// RULE1 - Full-scale current from bits 7..3, 4.8 to 29.6 mA, 0.8 mA steps.
// RULE2 - Flash current is (1 + (code+2)/10) x 29.6 mA, default 59.2 mA.
// RULE3 - Flash ends after 0 to 1.5 s, 100 ms steps, default 500 ms.
// RULE4 - Flash timeout counts on the shifted switching timebase.
// RULE5 - Leaving standby ramps current up over the upper ramp nibble time.
// RULE6 - Commanded standby ramps current down over the lower nibble time.
// RULE7 - Both ramp selectors have sixteen settings from 512 us, default 8 ms.
// RULE8 - Every ramp duration scales with the switching frequency shift.
// RULE9 - Transition settings apply only after the turn-on ramp completes.
// RULE10 - Brightness transition codes 1..15: fixed total time, 128-4096 ms.
// RULE11 - Brightness transition code 0 steps one level per microsecond.
// RULE12 - Duty changes use bits 6..4 as full-swing time, a fixed slope.
// RULE13 - Backlight to flash switching ramps at one step per microsecond.
// RULE14 - Current register bits 2..0 gate each sink, all enabled after reset.
// RULE15 - Bit 5 picks 500 kHz or 1 MHz, default 1 MHz; bits 7..6 shift it.
// RULE16 - Bits 5..3 of boost control two set the enabled switch drivers.
// RULE17 - Auto frequency enable is bit 7, off at reset; off means nominal.
// RULE18 - Auto: >= high 1 MHz, between 500 kHz, < low 250 kHz at half duty.
// RULE19 - Software sets the inductor bit for 10 uH, clears it otherwise.
// RULE20 - Bits 4..2 of boost control one select the overvoltage threshold.
// RULE21 - Overvoltage flag latches till enable toggle, soft reset, fault read.
// RULE22 - Mode 1..0: 00 standby, 01 backlight, 1X flash, enable pin high.
// RULE23 - The 11-bit level joins eight upper and three lower brightness bits.
// RULE24 - Enable pin low cuts current at once with no ramp.
// RULE25 - Full-scale codes map linearly from lowest, saturating at maximum.
// RULE26 - Auto mode brightness equal to the low threshold runs at 500 kHz.
`ifndef LED_RAMP_DEFS_SVH
`define LED_RAMP_DEFS_SVH
`define ADDR_ID          8'h00
`define ADDR_SOFT_RESET  8'h01
`define ADDR_MODE        8'h02
`define ADDR_LED_CUR     8'h03
`define ADDR_BOOST1      8'h04
`define ADDR_BOOST2      8'h05
`define ADDR_BRIGHT_LSB  8'h06
`define ADDR_BRIGHT_MSB  8'h07
`define ADDR_ON_OFF      8'h09
`define ADDR_TRANS       8'h0a
`define ADDR_FLASH       8'h0b
`define ADDR_AF_HIGH     8'h0c
`define ADDR_AF_LOW      8'h0d
`define ADDR_FAULT       8'h0e
// Identity value is arbitrary
`define ID_VALUE         8'h5a
`define RST_MODE         8'h00
`define RST_LED_CUR      8'h9f
`define RST_BOOST1       8'h2e
`define RST_BOOST2       8'h00
`define RST_BRIGHT_LSB   8'h07
`define RST_BRIGHT_MSB   8'hff
`define RST_ON_OFF       8'h44
`define RST_TRANS        8'h00
`define RST_FLASH        8'h58
`define RST_AF           8'h00
`define MODE_MASK        8'h17
`define LSB_MASK         8'h07
`define PWM_EN_BIT       4
`define FAULT_OVP_BIT    1
`define FS_MIN_X10       9'h030
`define FS_STEP_X10      9'h008
`define FS_MAX_X10       9'h128
`define FL_BASE_X100     13'hb90
`define FL_STEP_X100     13'h128
`define FL_OFFSET        13'h002
`define LEVEL_MAX        11'h7ff
`define CLK_PERIOD_NS    8
`define US_NS            1000
`define US_TICK_CYC      (`US_NS / `CLK_PERIOD_NS)
`define SHIFT_CYC        8'h0c
`define FLASH_STEP_MS    100
`define US_PER_MS        32'h000003e8
`define RAMP_FIRST_US    24'h000200
`define RAMP_BASE_US     24'h0001f4
`define TRANS_BASE_MS    13'h0080
`define PWM_BASE_MS      13'h0010
`endif

// ### rtl/led_ramp_pkg.sv
// Types shared by the LED ramp and boost control block
package led_ramp_pkg;
  typedef enum logic [1:0] {freq_250k, freq_500k, freq_1m} boost_freq_type;
  typedef enum logic [1:0] {st_off, st_ramp_on, st_on, st_ramp_off}
    ramp_state_type;
  typedef struct packed {
    logic       write;
    logic       read;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_type;
  typedef struct packed {
    boost_freq_type freq;
    logic           half_duty;
    logic [1:0]     shift;
    logic [2:0]     drivers;
    logic           large_ind;
    logic [2:0]     ovp_sel;
    logic           enable;
  } boost_ctrl_type;
endpackage : led_ramp_pkg

// ### rtl/led_current_ramp_and_boost_control.sv
// LED current ramp, flash timeout and boost control logic
`timescale 1ns/1ps
`include "led_ramp_defs.svh"
module led_current_ramp_and_boost_control #(
  parameter logic [7:0]  TICK_CYC      = 8'(`US_TICK_CYC),
  parameter int unsigned FLASH_STEP_US = `FLASH_STEP_MS * `US_PER_MS
) (
  // Clock and reset
  input  wire logic                        clk_i,
  input  wire logic                        rst_n_i,
  // Pins and analog status
  input  wire logic                        hardware_enable_pin_i,
  input  wire logic                        overvoltage_protection_trip_i,
  input  wire logic [10:0]                 pwm_duty_i,
  // Register port
  input  wire led_ramp_pkg::reg_req_type   reg_req_i,
  output logic [7:0]                       reg_rdata_o,
  // Current sinks
  output logic [2:0]                       sink_enable_o,
  output logic [10:0]                      sink_level_o,
  output logic                             flash_select_o,
  output logic [8:0]                       full_scale_current_o,
  output logic [12:0]                      flash_current_o,
  // Boost stage
  output led_ramp_pkg::boost_ctrl_type     boost_ctrl_o
);
  import led_ramp_pkg::*;

  logic [7:0]     mode_reg;
  logic [7:0]     cur_reg;
  logic [7:0]     b1_reg;
  logic [7:0]     b2_reg;
  logic [7:0]     lsb_reg;
  logic [7:0]     msb_reg;
  logic [7:0]     onoff_reg;
  logic [7:0]     trans_reg;
  logic [7:0]     flash_reg;
  logic [7:0]     afh_reg;
  logic [7:0]     afl_reg;
  logic           ovp_flag_reg;
  logic           soft_reset;
  logic           reg_clear;
  logic           fault_read;
  logic [7:0]     rd_value;
  logic [7:0]     tick_cnt_reg;
  logic [7:0]     tick_period;
  logic           us_tick;
  logic           is_flash;
  logic           pwm_en;
  logic           mode_active;
  logic [10:0]    bright_code;
  logic [10:0]    target;
  logic [10:0]    target_prev_reg;
  logic           flash_prev_reg;
  logic [10:0]    level_reg;
  logic [10:0]    diff;
  logic [31:0]    acc_reg;
  logic [10:0]    span_reg;
  logic [31:0]    total_reg;
  logic [10:0]    span_next;
  logic [31:0]    total_next;
  logic [31:0]    on_total;
  logic [31:0]    off_total;
  logic           load;
  logic           step;
  ramp_state_type state_reg;
  ramp_state_type state_next;
  logic [31:0]    flash_cnt_reg;
  logic [31:0]    flash_limit;
  logic           flash_expired_reg;
  boost_freq_type freq_sel;

  // Shortest selector gives 512 us, the rest double from 1 ms
  function automatic logic [23:0] onoff_us(input logic [3:0] c);
    return (c == 4'h0) ? `RAMP_FIRST_US : (`RAMP_BASE_US << c);
  endfunction : onoff_us

  // Multiples of the shortest brightness transition time
  function automatic logic [5:0] trans_mult(input logic [3:0] c);
    case (c)
      4'h1:    return 6'h01;
      4'h2:    return 6'h02;
      4'h3:    return 6'h03;
      4'h4:    return 6'h04;
      4'h5:    return 6'h06;
      4'h6:    return 6'h08;
      4'h7:    return 6'h0a;
      4'h8:    return 6'h0c;
      4'h9:    return 6'h0e;
      4'ha:    return 6'h10;
      4'hb:    return 6'h14;
      4'hc:    return 6'h18;
      4'hd:    return 6'h1c;
      4'he:    return 6'h1e;
      default: return 6'h20;
    endcase
  endfunction : trans_mult

  function automatic logic [31:0] ms_cycles(input logic [12:0] ms,
                                            input logic [7:0]  per);
    return 32'(ms) * `US_PER_MS * 32'(per);
  endfunction : ms_cycles

  // Register file; enable pin low or soft reset restores defaults
  assign soft_reset = reg_req_i.write &&
                      reg_req_i.addr == `ADDR_SOFT_RESET &&
                      reg_req_i.wdata[0];
  assign reg_clear  = !hardware_enable_pin_i || soft_reset;
  assign fault_read = reg_req_i.read && reg_req_i.addr == `ADDR_FAULT;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mode_reg  <= `RST_MODE;
      cur_reg   <= `RST_LED_CUR;
      b1_reg    <= `RST_BOOST1;
      b2_reg    <= `RST_BOOST2;
      lsb_reg   <= `RST_BRIGHT_LSB;
      msb_reg   <= `RST_BRIGHT_MSB;
      onoff_reg <= `RST_ON_OFF;
      trans_reg <= `RST_TRANS;
      flash_reg <= `RST_FLASH;
      afh_reg   <= `RST_AF;
      afl_reg   <= `RST_AF;
    end else if (reg_clear) begin
      mode_reg  <= `RST_MODE;
      cur_reg   <= `RST_LED_CUR;
      b1_reg    <= `RST_BOOST1;
      b2_reg    <= `RST_BOOST2;
      lsb_reg   <= `RST_BRIGHT_LSB;
      msb_reg   <= `RST_BRIGHT_MSB;
      onoff_reg <= `RST_ON_OFF;
      trans_reg <= `RST_TRANS;
      flash_reg <= `RST_FLASH;
      afh_reg   <= `RST_AF;
      afl_reg   <= `RST_AF;
    end else if (reg_req_i.write) begin
      if (reg_req_i.addr == `ADDR_MODE) begin
        mode_reg <= reg_req_i.wdata & `MODE_MASK;
      end else if (reg_req_i.addr == `ADDR_LED_CUR) begin
        cur_reg <= reg_req_i.wdata;
      end else if (reg_req_i.addr == `ADDR_BOOST1) begin
        b1_reg <= reg_req_i.wdata;
      end else if (reg_req_i.addr == `ADDR_BOOST2) begin
        b2_reg <= reg_req_i.wdata;
      end else if (reg_req_i.addr == `ADDR_BRIGHT_LSB) begin
        lsb_reg <= reg_req_i.wdata & `LSB_MASK;
      end else if (reg_req_i.addr == `ADDR_BRIGHT_MSB) begin
        msb_reg <= reg_req_i.wdata;
      end else if (reg_req_i.addr == `ADDR_ON_OFF) begin
        onoff_reg <= reg_req_i.wdata;
      end else if (reg_req_i.addr == `ADDR_TRANS) begin
        trans_reg <= reg_req_i.wdata;
      end else if (reg_req_i.addr == `ADDR_FLASH) begin
        flash_reg <= reg_req_i.wdata;
      end else if (reg_req_i.addr == `ADDR_AF_HIGH) begin
        afh_reg <= reg_req_i.wdata;
      end else if (reg_req_i.addr == `ADDR_AF_LOW) begin
        afl_reg <= reg_req_i.wdata;
      end
    end
  end

  always_comb begin
    if (reg_req_i.addr == `ADDR_ID) begin
      rd_value = `ID_VALUE;
    end else if (reg_req_i.addr == `ADDR_MODE) begin
      rd_value = mode_reg;
    end else if (reg_req_i.addr == `ADDR_LED_CUR) begin
      rd_value = cur_reg;
    end else if (reg_req_i.addr == `ADDR_BOOST1) begin
      rd_value = b1_reg;
    end else if (reg_req_i.addr == `ADDR_BOOST2) begin
      rd_value = b2_reg;
    end else if (reg_req_i.addr == `ADDR_BRIGHT_LSB) begin
      rd_value = lsb_reg;
    end else if (reg_req_i.addr == `ADDR_BRIGHT_MSB) begin
      rd_value = msb_reg;
    end else if (reg_req_i.addr == `ADDR_ON_OFF) begin
      rd_value = onoff_reg;
    end else if (reg_req_i.addr == `ADDR_TRANS) begin
      rd_value = trans_reg;
    end else if (reg_req_i.addr == `ADDR_FLASH) begin
      rd_value = flash_reg;
    end else if (reg_req_i.addr == `ADDR_AF_HIGH) begin
      rd_value = afh_reg;
    end else if (reg_req_i.addr == `ADDR_AF_LOW) begin
      rd_value = afl_reg;
    end else if (reg_req_i.addr == `ADDR_FAULT) begin
      rd_value = 8'(ovp_flag_reg) << `FAULT_OVP_BIT;
    end else begin
      rd_value = 8'h00;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      reg_rdata_o <= 8'h00;
    end else if (reg_req_i.read) begin
      reg_rdata_o <= rd_value;
    end
  end

  // A trip in the clearing cycle keeps the flag set
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ovp_flag_reg <= 1'b0;
    end else if (overvoltage_protection_trip_i) begin
      ovp_flag_reg <= 1'b1;                                     // RULE21
    end else if (reg_clear || fault_read) begin
      ovp_flag_reg <= 1'b0;                                     // RULE21
    end
  end

  // Microsecond timebase follows the frequency shift, so do all ramps
  always_comb begin
    case (b1_reg[7:6])
      2'b01:   tick_period = TICK_CYC - `SHIFT_CYC;             // RULE8
      2'b10:   tick_period = TICK_CYC + `SHIFT_CYC;             // RULE8
      default: tick_period = TICK_CYC;
    endcase
  end
  assign us_tick = tick_cnt_reg >= tick_period - 8'h01;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tick_cnt_reg <= 8'h00;
    end else if (us_tick) begin
      tick_cnt_reg <= 8'h00;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 8'h01;
    end
  end

  // Target level
  assign is_flash    = mode_reg[1];                             // RULE22
  assign pwm_en      = mode_reg[`PWM_EN_BIT];
  assign bright_code = {msb_reg, lsb_reg[2:0]};                 // RULE23
  assign mode_active = hardware_enable_pin_i && !ovp_flag_reg &&
                       mode_reg[1:0] != 2'b00 &&
                       !flash_expired_reg;                      // RULE22
  assign target = !mode_active ? 11'h000 :
                  is_flash     ? `LEVEL_MAX :
                  pwm_en       ? pwm_duty_i : bright_code;
  assign diff = (target > level_reg) ? target - level_reg
                                     : level_reg - target;
  assign on_total  = 32'(onoff_us(onoff_reg[7:4])) *
                     32'(tick_period);                          // RULE5 RULE7
  assign off_total = 32'(onoff_us(onoff_reg[3:0])) *
                     32'(tick_period);                          // RULE6 RULE7

  // Ramp sequencing; a load restarts the step engine
  always_comb begin
    state_next = state_reg;
    load       = 1'b0;
    span_next  = diff;
    total_next = on_total;
    case (state_reg)
      st_off: begin
        if (mode_active) begin
          state_next = st_ramp_on;                              // RULE5
          load       = 1'b1;
        end
      end
      st_ramp_on: begin
        if (!mode_active) begin
          state_next = st_ramp_off;
          load       = 1'b1;
          total_next = off_total;
        end else if (level_reg == target) begin
          state_next = st_on;                                   // RULE9
        end else if (target != target_prev_reg) begin
          load = 1'b1;
        end
      end
      st_on: begin
        if (!mode_active) begin
          state_next = st_ramp_off;                             // RULE6
          load       = 1'b1;
          total_next = off_total;
        end else if (target != target_prev_reg) begin
          load = 1'b1;
          if (is_flash != flash_prev_reg) begin
            span_next  = 11'h001;                               // RULE13
            total_next = 32'(tick_period);
          end else if (pwm_en) begin
            span_next  = `LEVEL_MAX;                            // RULE12
            total_next = ms_cycles(`PWM_BASE_MS << trans_reg[6:4],
                                   tick_period);
          end else if (trans_reg[3:0] == 4'h0) begin
            span_next  = 11'h001;                               // RULE11
            total_next = 32'(tick_period);
          end else begin
            total_next = ms_cycles(13'(trans_mult(trans_reg[3:0])) *
                                   `TRANS_BASE_MS, tick_period); // RULE10
          end
        end
      end
      default: begin
        if (mode_active) begin
          state_next = st_ramp_on;
          load       = 1'b1;
        end else if (level_reg == 11'h000) begin
          state_next = st_off;
        end
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_reg       <= st_off;
      target_prev_reg <= 11'h000;
      flash_prev_reg  <= 1'b0;
    end else begin
      state_reg       <= hardware_enable_pin_i ? state_next : st_off;
      target_prev_reg <= target;
      flash_prev_reg  <= is_flash;
    end
  end

  // Fractional stepping: span steps spread evenly over total cycles.
  // A fixed span of one gives one step per total instead.
  assign step = !load && level_reg != target &&
                acc_reg + 32'(span_reg) >= total_reg;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      level_reg <= 11'h000;
      acc_reg   <= 32'h0;
      span_reg  <= 11'h000;
      total_reg <= 32'h1;
    end else if (!hardware_enable_pin_i) begin
      level_reg <= 11'h000;                                     // RULE24
      acc_reg   <= 32'h0;
    end else if (load) begin
      acc_reg   <= 32'h0;
      span_reg  <= span_next;
      total_reg <= total_next;
    end else if (step) begin
      level_reg <= (target > level_reg) ? level_reg + 11'h001
                                        : level_reg - 11'h001;
      acc_reg   <= acc_reg + 32'(span_reg) - total_reg;
    end else if (level_reg != target) begin
      acc_reg   <= acc_reg + 32'(span_reg);
    end
  end

  // Flash timeout runs on the shifted microsecond tick
  assign flash_limit = 32'(flash_reg[7:4]) * FLASH_STEP_US;     // RULE3

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      flash_cnt_reg     <= 32'h0;
      flash_expired_reg <= 1'b0;
    end else if (!is_flash) begin
      flash_cnt_reg     <= 32'h0;
      flash_expired_reg <= 1'b0;
    end else if (!flash_expired_reg && state_reg != st_off) begin
      if (flash_cnt_reg >= flash_limit) begin
        flash_expired_reg <= 1'b1;                              // RULE3
      end else if (us_tick) begin
        flash_cnt_reg <= flash_cnt_reg + 32'h1;                 // RULE4
      end
    end
  end

  // Frequency choice; equal to the low threshold stays at 500 kHz
  always_comb begin
    if (!b2_reg[7]) begin
      freq_sel = b1_reg[5] ? freq_1m : freq_500k;               // RULE15 RULE17
    end else if (msb_reg >= afh_reg) begin
      freq_sel = freq_1m;                                       // RULE18
    end else if (msb_reg < afl_reg) begin
      freq_sel = freq_250k;                                     // RULE18
    end else begin
      freq_sel = freq_500k;                                     // RULE26
    end
  end

  // Registered outputs
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sink_enable_o        <= 3'h0;
      flash_select_o       <= 1'b0;
      full_scale_current_o <= 9'h000;
      flash_current_o      <= 13'h0000;
      boost_ctrl_o         <= '0;
    end else begin
      sink_enable_o  <= (hardware_enable_pin_i && state_reg != st_off)
                        ? cur_reg[2:0] : 3'h0;                  // RULE14
      flash_select_o <= is_flash && mode_active;
      full_scale_current_o <=
        (`FS_MIN_X10 + `FS_STEP_X10 * 9'(cur_reg[7:3]) > `FS_MAX_X10)
        ? `FS_MAX_X10
        : `FS_MIN_X10 + `FS_STEP_X10 * 9'(cur_reg[7:3]);        // RULE1 RULE25
      flash_current_o <= `FL_BASE_X100 + `FL_STEP_X100 *
                         (13'(flash_reg[3:0]) + `FL_OFFSET);    // RULE2
      boost_ctrl_o.freq      <= freq_sel;
      boost_ctrl_o.half_duty <= freq_sel == freq_250k;          // RULE18
      boost_ctrl_o.shift     <= b1_reg[7:6];                    // RULE15
      boost_ctrl_o.drivers   <= b2_reg[5:3];                    // RULE16
      boost_ctrl_o.large_ind <= b2_reg[6];
      boost_ctrl_o.ovp_sel   <= b1_reg[4:2];                    // RULE20
      boost_ctrl_o.enable    <= hardware_enable_pin_i && !ovp_flag_reg &&
                                level_reg != 11'h000;
    end
  end
  assign sink_level_o = level_reg;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence seq_unit_step;
    step && span_reg == 11'h001;
  endsequence
  sequence seq_quiet;
    !step [*8];
  endsequence

  a_fs_current: assert property ($past(rst_n_i) |->            // RULE1
    full_scale_current_o ==
    `FS_MIN_X10 + `FS_STEP_X10 * 9'($past(cur_reg[7:3])))
    else $error("full-scale current mismatch");
  a_flash_current: assert property ($past(rst_n_i) |->         // RULE2
    flash_current_o == `FL_BASE_X100 +
    `FL_STEP_X100 * (13'($past(flash_reg[3:0])) + `FL_OFFSET))
    else $error("flash current mismatch");
  a_hardware_enable_pin_cut: assert property (!hardware_enable_pin_i |=>     // RULE24
    sink_level_o == 11'h000 && state_reg == st_off)
    else $error("current not cut by enable pin");
  a_sink_gate: assert property (hardware_enable_pin_i &&       // RULE14
    state_reg == st_on |=> sink_enable_o == $past(cur_reg[2:0]))
    else $error("sink gating mismatch");
  a_auto_high: assert property (b2_reg[7] &&                   // RULE18
    msb_reg >= afh_reg |=> boost_ctrl_o.freq == freq_1m)
    else $error("auto frequency high wrong");
  a_auto_low_edge: assert property (b2_reg[7] &&               // RULE26
    msb_reg < afh_reg && msb_reg == afl_reg
    |=> boost_ctrl_o.freq == freq_500k && !boost_ctrl_o.half_duty)
    else $error("low threshold edge wrong");
  a_auto_off: assert property (!b2_reg[7] && b1_reg[5]         // RULE17
    |=> boost_ctrl_o.freq == freq_1m)
    else $error("nominal frequency not kept");
  a_ovp_hold: assert property (ovp_flag_reg && !reg_clear &&   // RULE21
    !fault_read |=> ovp_flag_reg)
    else $error("overvoltage flag dropped");
  a_unit_spacing: assert property (seq_unit_step |=>           // RULE11
    seq_quiet)
    else $error("unit ramp stepped too fast");
  a_flash_expire: assert property (is_flash && !reg_clear &&   // RULE3
    !reg_req_i.write && state_reg != st_off &&
    !flash_expired_reg && flash_cnt_reg >= flash_limit
    |=> flash_expired_reg)
    else $error("flash timeout missed");
  a_on_done: assert property (state_reg == st_ramp_on &&       // RULE9
    mode_active && level_reg == target |=> state_reg == st_on)
    else $error("turn-on ramp not completed");
  a_off_ramp: assert property (state_reg == st_on &&           // RULE6
    !mode_active && hardware_enable_pin_i
    |=> state_reg == st_ramp_off && total_reg == $past(off_total))
    else $error("ramp-down not loaded");
endmodule : led_current_ramp_and_boost_control

// ### verif/boost_stage_model.sv
// Boost stage stand-in that reports an output overvoltage on request
`timescale 1ns/1ps
module boost_stage_model (
  // Clock, reset and stimulus
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic trip_req_i,
  // Comparator output
  output logic      trip_o
);
  // Comparator never holds its level, so the flag must latch inside
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) trip_o <= 1'b0;
    else trip_o <= trip_req_i;
  end
endmodule : boost_stage_model

// ### verif/led_current_ramp_and_boost_control_bench.sv
// Self-checking bench for the LED ramp and boost control block
`timescale 1ns/1ps
`include "led_ramp_defs.svh"
module led_current_ramp_and_boost_control_bench;
  import led_ramp_pkg::*;
  logic           clk_i = 0, rst_n_i = 0, trip_req = 0;
  logic           hardware_enable_pin_i = 1, overvoltage_protection_trip_i;
  logic [10:0]    pwm_duty_i = 11'h000, sink_level_o;
  reg_req_type    reg_req_i = '0;
  logic [7:0]     reg_rdata_o, c, d;
  logic [2:0]     sink_enable_o;
  logic           flash_select_o;
  logic [8:0]     full_scale_current_o;
  logic [12:0]    flash_current_o;
  boost_ctrl_type boost_ctrl_o;
  int             error_cnt = 0, samples_checked = 0;
  logic [7:0]     msb[5] = '{8'h90, 8'h80, 8'h60, 8'h40, 8'h10};
  boost_freq_type fq[5] = '{freq_1m, freq_1m, freq_500k, freq_500k, freq_250k};
  always #4 clk_i = ~clk_i;
  led_current_ramp_and_boost_control #(.TICK_CYC(8'h15), .FLASH_STEP_US(50))
    uut (.clk_i, .rst_n_i, .hardware_enable_pin_i,
    .overvoltage_protection_trip_i, .pwm_duty_i, .reg_req_i, .reg_rdata_o,
    .sink_enable_o, .sink_level_o, .flash_select_o, .full_scale_current_o,
    .flash_current_o, .boost_ctrl_o);
  boost_stage_model partner (.clk_i, .rst_n_i, .trip_req_i(trip_req),
    .trip_o(overvoltage_protection_trip_i));
  task automatic chk(string n, logic [15:0] s, logic [15:0] e);
    samples_checked++;
    if (s !== e) begin
      error_cnt++;
      $display("[ERR] %s exp %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic cyc(int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : cyc
  task automatic wr(logic [7:0] a, logic [7:0] v);
    reg_req_i = '{1'b1, 1'b0, a, v};
    cyc(1);
    reg_req_i = '0;
    cyc(1);
  endtask : wr
  task automatic rd(logic [7:0] a);
    reg_req_i = '{1'b0, 1'b1, a, 8'h00};
    cyc(1);
    reg_req_i = '0;
    cyc(1);
  endtask : rd
  task automatic wrap_up();
    $display("checked %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : wrap_up
  initial begin
    #500000;
    error_cnt++;
    wrap_up();
  end
  initial begin
    void'($urandom(40167));
    cyc(3);
    rst_n_i = 1;
    cyc(1);
    chk("fs_rst", full_scale_current_o, 16'd200);
    chk("fl_rst", flash_current_o, 16'd5920);
    chk("freq_rst", boost_ctrl_o.freq, freq_1m);
    rd(`ADDR_FLASH);
    chk("flash_reg", reg_rdata_o, `RST_FLASH);
    rd(8'h3f);
    chk("unmapped", reg_rdata_o, 8'h00);
    c = 8'($urandom);
    d = 8'($urandom);
    wr(`ADDR_LED_CUR, c);
    wr(`ADDR_FLASH, d);
    wr(`ADDR_ON_OFF, 8'h00);
    wr(`ADDR_MODE, 8'h01);
    cyc(300);
    chk("fs", full_scale_current_o, 16'(48 + 8 * c[7:3]));
    chk("fl", flash_current_o, 16'(2960 + 296 * (d[3:0] + 2)));
    chk("sink_en", sink_enable_o, c[2:0]);
    chk("ramp_up", sink_level_o != 0 && sink_level_o < 11'h7ff, 1);
    trip_req = 1;
    cyc(1);
    trip_req = 0;
    cyc(3);
    chk("boost_off", boost_ctrl_o.enable, 0);
    rd(`ADDR_FAULT);
    chk("ovp_flag", reg_rdata_o[1], 1);
    rd(`ADDR_FAULT);
    chk("ovp_clr", reg_rdata_o[1], 0);
    wr(`ADDR_FLASH, {4'h1, d[3:0]});
    wr(`ADDR_MODE, 8'h02);
    cyc(2);
    chk("flash_sel", flash_select_o, 1);
    cyc(990);
    chk("flash_hold", flash_select_o, 1);
    cyc(80);
    chk("flash_end", flash_select_o, 0);
    hardware_enable_pin_i = 0;
    cyc(1);
    chk("cut", sink_level_o, 0);
    hardware_enable_pin_i = 1;
    rd(`ADDR_LED_CUR);
    chk("cur_dflt", reg_rdata_o, 8'h9f);
    wr(`ADDR_BOOST1, {3'b010, c[4:2], 2'b00});
    cyc(3);
    chk("nominal", boost_ctrl_o.freq, freq_500k);
    chk("shift", boost_ctrl_o.shift, 2'b01);
    chk("ovp_sel", boost_ctrl_o.ovp_sel, c[4:2]);
    wr(`ADDR_AF_HIGH, 8'h80);
    wr(`ADDR_AF_LOW, 8'h40);
    wr(`ADDR_BOOST2, {2'b11, c[5:3], 3'h0});
    foreach (msb[i]) begin
      wr(`ADDR_BRIGHT_MSB, msb[i]);
      cyc(3);
      chk("auto_freq", boost_ctrl_o.freq, fq[i]);
    end
    chk("half_duty", boost_ctrl_o.half_duty, 1);
    chk("drivers", boost_ctrl_o.drivers, c[5:3]);
    chk("inductor", boost_ctrl_o.large_ind, 1);
    // Shift up leaves 9 clocks per tick, so 512 us is 4608 clocks
    wr(`ADDR_ON_OFF, 8'h00);
    wr(`ADDR_BRIGHT_MSB, 8'h00);
    wr(`ADDR_MODE, 8'h01);
    cyc(4700);
    chk("on_done", sink_level_o, 7);
    wr(`ADDR_BRIGHT_LSB, 8'h02);
    cyc(20);
    chk("unit_mid", sink_level_o > 2 && sink_level_o < 7, 1);
    cyc(40);
    chk("unit_end", sink_level_o, 2);
    wr(`ADDR_MODE, 8'h00);
    cyc(100);
    chk("off_ramp", sink_level_o, 2);
    cyc(4700);
    chk("off_done", sink_level_o, 0);
    wrap_up();
  end
endmodule : led_current_ramp_and_boost_control_bench
